// >>> verilog/rx_link_status_pkg.sv
package rx_link_status_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] RX_LINK_STATUS_ONE_ADDR = 8'h4D;
  localparam logic [7:0] PORT_PAGE_SELECT_ADDR = 8'h4C;
  localparam logic [7:0] RX_LINK_STATUS_ONE_RESET = 8'h00;
  localparam logic [7:0] READ_MISS_DATA = 8'h00;

  // ****************************************************************
  // field positions of the status byte
  // ****************************************************************
  localparam int PORT_NUM_LSB = 6;
  localparam int PORT_NUM_MSB = 7;
  localparam int CRC_FLAG_BIT = 5;
  localparam int LOCK_CHANGE_BIT = 4;
  localparam int SEQUENCE_FLAG_BIT = 3;
  localparam int PARITY_FLAG_BIT = 2;
  localparam int PASS_BIT = 1;
  localparam int LOCKED_BIT = 0;

  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int NUM_PORTS = 4;
  localparam int PORT_SEL_W = 2;
  localparam int PARITY_COUNT_W = 16;

  // ****************************************************************
  // per-port inputs from the receiver and control-channel logic
  // ****************************************************************
  typedef struct packed {
    logic enhanced_error_enable;
    logic ctrl_channel_summary_flag;
    logic crc_error_pulse;
    logic sequence_error_pulse;
    logic receiver_locked;
    logic receiver_pass;
    logic parity_count_clear;
  } rx_port_events_s;

  // sticky flags held per port
  typedef struct packed {
    logic ctrl_channel_crc_flag;
    logic lock_change_flag;
    logic ctrl_channel_sequence_flag;
    logic parity_flag;
  } rx_port_flags_s;

  localparam rx_port_flags_s FLAGS_RESET = '{default: 1'b0};

endpackage : rx_link_status_pkg

// >>> verilog/rx_port_link_status.sv
`timescale 1ns/1ps
`default_nettype none

//
// Function
// RQ1 - bits 7:6 read back the currently selected read port number, read-only.
// RQ2 - bit 5 sets on forward control-channel CRC error, clears on read.
// RQ3 - bit 4 sets when lock status changed since last read, clears on read.
// RQ4 - enhanced mode off: bit 3 is sequence-error flag, clears on read.
// RQ5 - enhanced mode on: bit 3 is summary error, cleared via error-status read.
// RQ6 - bit 2 set while parity error count exceeds programmed limit.
// RQ7 - bit 2 not cleared by read; clears only when parity counts clear.
// RQ8 - bit 1 shows live receiver pass indication.
// RQ9 - bit 0 shows live receiver lock state.
// RQ10 - one status copy per port; host selects copy via page select first.
// RQ11 - read selection 00..11 picks port 0..3 register block.
// RQ12 - read clears only returned bits; same-cycle events stay pending.
module rx_port_link_status #(
  parameter int NUM_PORTS = rx_link_status_pkg::NUM_PORTS,
  parameter int PARITY_COUNT_W = rx_link_status_pkg::PARITY_COUNT_W
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic rd_strobe_i,
  input wire logic [7:0] rd_addr_i,
  input wire logic [rx_link_status_pkg::PORT_SEL_W-1:0] port_page_select_i,
  input wire rx_link_status_pkg::rx_port_events_s [NUM_PORTS-1:0] port_events_i,
  input wire logic [NUM_PORTS-1:0][PARITY_COUNT_W-1:0] parity_error_count_i,
  input wire logic [NUM_PORTS-1:0][PARITY_COUNT_W-1:0] parity_limit_i,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o,
  output logic rd_hit_o
);

  // ****************************************************************
  // state
  // ****************************************************************
  // sticky flags, one bit per port copy
  logic [NUM_PORTS-1:0] crc_flag_q;
  logic [NUM_PORTS-1:0] lock_change_q;
  logic [NUM_PORTS-1:0] sequence_flag_q;
  logic [NUM_PORTS-1:0] parity_flag_q;
  logic [NUM_PORTS-1:0] locked_prev_q;
  logic [NUM_PORTS-1:0] read_clear;
  logic [NUM_PORTS-1:0] parity_over;
  logic status_read;
  rx_link_status_pkg::rx_port_flags_s sel_flags;
  logic [7:0] status_byte;

  // ****************************************************************
  // status byte assembly for one port
  // ****************************************************************
  function automatic logic [7:0] build_status(
    input logic [rx_link_status_pkg::PORT_SEL_W-1:0] port_num,
    input rx_link_status_pkg::rx_port_flags_s flags,
    input rx_link_status_pkg::rx_port_events_s ev
  );
    logic [7:0] b;
    b = rx_link_status_pkg::RX_LINK_STATUS_ONE_RESET;
    b[rx_link_status_pkg::PORT_NUM_MSB:rx_link_status_pkg::PORT_NUM_LSB] = port_num; // [RQ1]
    b[rx_link_status_pkg::CRC_FLAG_BIT] = flags.ctrl_channel_crc_flag; // [RQ2]
    b[rx_link_status_pkg::LOCK_CHANGE_BIT] = flags.lock_change_flag; // [RQ3]
    // bit 3 meaning switches with the enhanced error setting
    if (ev.enhanced_error_enable)
    begin
      b[rx_link_status_pkg::SEQUENCE_FLAG_BIT] = ev.ctrl_channel_summary_flag; // [RQ5]
    end
    else
    begin
      b[rx_link_status_pkg::SEQUENCE_FLAG_BIT] = flags.ctrl_channel_sequence_flag; // [RQ4]
    end
    b[rx_link_status_pkg::PARITY_FLAG_BIT] = flags.parity_flag; // [RQ6]
    b[rx_link_status_pkg::PASS_BIT] = ev.receiver_pass; // [RQ8]
    b[rx_link_status_pkg::LOCKED_BIT] = ev.receiver_locked; // [RQ9]
    return b;
  endfunction : build_status

  // ****************************************************************
  // one-hot mask of the port copy a read returns
  // ****************************************************************
  function automatic logic [NUM_PORTS-1:0] port_mask(
    input logic enable,
    input logic [rx_link_status_pkg::PORT_SEL_W-1:0] port_num
  );
    logic [NUM_PORTS-1:0] m;
    m = '0;
    for (int p = 0; p < NUM_PORTS; p++)
    begin
      if (enable && (port_num == p[rx_link_status_pkg::PORT_SEL_W-1:0]))
      begin
        m[p] = 1'h1;
      end
    end
    return m;
  endfunction : port_mask

  // ****************************************************************
  // next value of a read-clear flag
  // ****************************************************************
  // the event wins, so one arriving with the read stays for the next read
  function automatic logic sticky_next(
    input logic flag,
    input logic set,
    input logic clear
  );
    return set || (flag && !clear);
  endfunction : sticky_next

  // ****************************************************************
  // read decode and page selection
  // ****************************************************************
  assign status_read = rd_strobe_i && (rd_addr_i == rx_link_status_pkg::RX_LINK_STATUS_ONE_ADDR);
  assign read_clear = port_mask(status_read, port_page_select_i); // [RQ10] [RQ11]

  // ****************************************************************
  // flags of the selected port copy
  // ****************************************************************
  // the page select value indexes the port copy directly
  always_comb
  begin
    sel_flags = rx_link_status_pkg::FLAGS_RESET;
    sel_flags.ctrl_channel_crc_flag = crc_flag_q[port_page_select_i];
    sel_flags.lock_change_flag = lock_change_q[port_page_select_i];
    sel_flags.ctrl_channel_sequence_flag = sequence_flag_q[port_page_select_i];
    sel_flags.parity_flag = parity_flag_q[port_page_select_i];
  end

  assign status_byte = build_status(port_page_select_i,
                                    sel_flags,
                                    port_events_i[port_page_select_i]); // [RQ10] [RQ11]

  // ****************************************************************
  // parity count compare
  // ****************************************************************
  // strictly greater: a count equal to the limit leaves the flag low
  always_comb
  begin
    parity_over = '0;
    for (int p = 0; p < NUM_PORTS; p++)
    begin
      parity_over[p] = (parity_error_count_i[p] > parity_limit_i[p]); // [RQ6]
    end
  end

  // ****************************************************************
  // control-channel crc flag
  // ****************************************************************
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      crc_flag_q <= '0;
    end
    else
    begin
      for (int p = 0; p < NUM_PORTS; p++)
      begin
        crc_flag_q[p] <= sticky_next(crc_flag_q[p],
                                     port_events_i[p].crc_error_pulse,
                                     read_clear[p]); // [RQ2] [RQ12]
      end
    end
  end

  // ****************************************************************
  // lock change flag
  // ****************************************************************
  // the history resets low, so a receiver locked at release reports a change
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      lock_change_q <= '0;
    end
    else
    begin
      for (int p = 0; p < NUM_PORTS; p++)
      begin
        lock_change_q[p] <= sticky_next(lock_change_q[p],
                                        port_events_i[p].receiver_locked != locked_prev_q[p],
                                        read_clear[p]); // [RQ3] [RQ12]
      end
    end
  end

  // ****************************************************************
  // control-channel sequence flag
  // ****************************************************************
  // with enhanced errors on, reads leave this hidden flag alone
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sequence_flag_q <= '0;
    end
    else
    begin
      for (int p = 0; p < NUM_PORTS; p++)
      begin
        sequence_flag_q[p] <= sticky_next(sequence_flag_q[p],
                                          port_events_i[p].sequence_error_pulse,
                                          read_clear[p] && !port_events_i[p].enhanced_error_enable); // [RQ4] [RQ12]
      end
    end
  end

  // ****************************************************************
  // parity threshold flag
  // ****************************************************************
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      parity_flag_q <= '0;
    end
    else
    begin
      for (int p = 0; p < NUM_PORTS; p++)
      begin
        // a read never touches it; the count clear wins over a same-cycle set
        if (port_events_i[p].parity_count_clear)
        begin
          parity_flag_q[p] <= 1'h0; // [RQ7]
        end
        else if (parity_over[p])
        begin
          parity_flag_q[p] <= 1'h1; // [RQ6]
        end
      end
    end
  end

  // ****************************************************************
  // lock history for change detection
  // ****************************************************************
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      locked_prev_q <= '0;
    end
    else
    begin
      for (int p = 0; p < NUM_PORTS; p++)
      begin
        locked_prev_q[p] <= port_events_i[p].receiver_locked;
      end
    end
  end

  // ****************************************************************
  // read answer strobes
  // ****************************************************************
  // every read is answered, whatever its address
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rd_valid_o <= 1'h0;
    end
    else
    begin
      rd_valid_o <= rd_strobe_i;
    end
  end

  // only a read of the status register counts as a hit
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rd_hit_o <= 1'h0;
    end
    else
    begin
      rd_hit_o <= status_read;
    end
  end

  // ****************************************************************
  // read data return
  // ****************************************************************
  // a miss returns the idle pattern, so no stale byte leaks out
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rd_data_o <= rx_link_status_pkg::READ_MISS_DATA;
    end
    else
    begin
      if (status_read)
      begin
        rd_data_o <= status_byte; // [RQ12]
      end
      else
      begin
        rd_data_o <= rx_link_status_pkg::READ_MISS_DATA;
      end
    end
  end

endmodule : rx_port_link_status

`default_nettype wire

// >>> sim/rx_status_chk.sv
`timescale 1ns/1ps
`default_nettype none
module rx_status_chk (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic rd_strobe_i,
  input wire logic [7:0] rd_addr_i,
  input wire logic [1:0] port_page_select_i,
  input wire rx_link_status_pkg::rx_port_events_s [3:0] port_events_i,
  input wire logic [7:0] rd_data_o,
  input wire logic rd_valid_o,
  input wire logic rd_hit_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  wire logic hit = rd_strobe_i && rd_addr_i == 8'h4D;
  wire logic lk = port_events_i[port_page_select_i].receiver_locked;
  wire logic ps = port_events_i[port_page_select_i].receiver_pass;
  wire logic en = port_events_i[port_page_select_i].enhanced_error_enable;
  wire logic sm = port_events_i[port_page_select_i].ctrl_channel_summary_flag;
  valid_pulse_a: assert property (rd_strobe_i |=> rd_valid_o)
    else $error("read not answered");
  valid_idle_a: assert property (!rd_strobe_i |=> !rd_valid_o && rd_data_o == 8'h00)
    else $error("output without read");
  hit_addr_a: assert property (hit |=> rd_hit_o)
    else $error("hit missing");
  miss_quiet_a: assert property (rd_strobe_i && !hit |=> !rd_hit_o && rd_data_o == 8'h00)
    else $error("miss not quiet");
  port_field_a: assert property (hit |=> rd_data_o[7:6] == $past(port_page_select_i))
    else $error("port field wrong");
  locked_live_a: assert property (hit |=> rd_data_o[0] == $past(lk))
    else $error("lock bit wrong");
  pass_live_a: assert property (hit |=> rd_data_o[1] == $past(ps))
    else $error("pass bit wrong");
  hit_valid_a: assert property (rd_hit_o |-> rd_valid_o)
    else $error("hit without valid");
  enh_summary_a: assert property (hit && en |=> rd_data_o[3] == $past(sm))
    else $error("summary bit wrong");
  cover property (hit ##1 rd_data_o[5]);
  cover property (hit ##1 rd_data_o[2]);
  cover property (rd_strobe_i && !hit);
endmodule : rx_status_chk
`default_nettype wire

// >>> sim/link_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// host side: one-cycle read strobe, captures the answer
module link_host_model (
  input wire logic mclk_i,
  input wire logic go_i,
  input wire logic [7:0] addr_i,
  output logic rd_strobe_o,
  output logic [7:0] rd_addr_o,
  input wire logic [7:0] rd_data_i,
  input wire logic rd_valid_i,
  input wire logic rd_hit_i,
  output logic hit_o,
  output logic [7:0] data_o,
  output logic done_o
);
  initial rd_strobe_o = 0;
  initial done_o = 0;
  always @(posedge mclk_i)
  begin
    rd_strobe_o <= go_i;
    rd_addr_o <= addr_i;
    done_o <= rd_valid_i;
    if (rd_valid_i)
    begin
      data_o <= rd_data_i;
      hit_o <= rd_hit_i;
    end
  end
endmodule : link_host_model
`default_nettype wire

// >>> sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic mclk_i = 0, rst_n_i = 0, go = 0, rs, hv, dn, hh, hm;
  logic [7:0] ad = 8'h4D, ra, rdd, hd;
  logic [1:0] sel = 2'h0;
  rx_link_status_pkg::rx_port_events_s [3:0] ev = '0;
  logic [3:0][15:0] cnt = '0, lim = '0;
  int error_cnt = 0, checks_done = 0;
  always #12.5 mclk_i = ~mclk_i;
  rx_port_link_status rx_port_link_status_inst (.mclk_i, .rst_n_i, .rd_strobe_i(rs),
    .rd_addr_i(ra), .port_page_select_i(sel), .port_events_i(ev), .parity_error_count_i(cnt),
    .parity_limit_i(lim), .rd_data_o(rdd), .rd_valid_o(hv), .rd_hit_o(hh));
  link_host_model link_host_model_inst (.mclk_i, .go_i(go), .addr_i(ad), .rd_strobe_o(rs),
    .rd_addr_o(ra), .rd_data_i(rdd), .rd_valid_i(hv), .rd_hit_i(hh), .hit_o(hm),
    .data_o(hd), .done_o(dn));
  // ****
  // checking
  // ****
  task conclude;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  task cmp(input string n, input logic [7:0] e, input logic [7:0] s);
    checks_done++;
    if (s !== e)
    begin
      error_cnt++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask : cmp
  task rd(input logic [7:0] a, input logic [7:0] e, input string n);
    int i;
    i = 0;
    @(posedge mclk_i);
    #1 ad = a;
    go = 1;
    @(posedge mclk_i);
    #1 go = 0;
    while (dn !== 1'b1 && i < 4)
    begin
      @(posedge mclk_i);
      #1 i++;
    end
    if (dn !== 1'b1)
    begin
      error_cnt++;
      conclude();
    end
    else
    begin
      cmp(n, e, hd);
      cmp("hit", {7'h00, a == 8'h4D}, {7'h00, hm});
    end
  endtask : rd
  task pulse(input int p, input logic c);
    ev[p].crc_error_pulse = c;
    ev[p].sequence_error_pulse = 1;
    @(posedge mclk_i);
    #1 ev[p].crc_error_pulse = 0;
    ev[p].sequence_error_pulse = 0;
  endtask : pulse
  // ****
  // scenarios
  // ****
  task t_lock;
    for (int p = 0; p < 4; p++)
    begin
      ev[p].receiver_locked = 1;
      ev[p].receiver_pass = 1;
      sel = p[1:0];
      rd(8'h4D, {p[1:0], 6'b010011}, "lock");
      rd(8'h4D, {p[1:0], 6'b000011}, "lock2");
    end
    rd(8'h4C, 8'h00, "miss");
    $display("done lock");
  endtask : t_lock
  task t_crc;
    sel = 2'h1;
    pulse(1, 1);
    rd(8'h4D, 8'h6B, "crc");
    rd(8'h4D, 8'h43, "crc2");
    $display("done crc");
  endtask : t_crc
  task t_enh;
    sel = 2'h2;
    ev[2].enhanced_error_enable = 1;
    ev[2].ctrl_channel_summary_flag = 1;
    pulse(2, 0);
    rd(8'h4D, 8'h8B, "enh");
    rd(8'h4D, 8'h8B, "enh2");
    ev[2].ctrl_channel_summary_flag = 0;
    rd(8'h4D, 8'h83, "enh3");
    $display("done enh");
  endtask : t_enh
  task t_par;
    sel = 2'h3;
    cnt[3] = 16'h0005;
    lim[3] = 16'h0005;
    rd(8'h4D, 8'hC3, "par");
    cnt[3] = 16'h0006;
    rd(8'h4D, 8'hC7, "par2");
    rd(8'h4D, 8'hC7, "par3");
    cnt[3] = 16'h0000;
    ev[3].parity_count_clear = 1;
    @(posedge mclk_i);
    #1 ev[3].parity_count_clear = 0;
    rd(8'h4D, 8'hC3, "par4");
    $display("done par");
  endtask : t_par
  task t_same;
    int i;
    i = 0;
    sel = 2'h1;
    ad = 8'h4D;
    go = 1;
    @(posedge mclk_i);
    #1 go = 0;
    ev[1].crc_error_pulse = 1;
    @(posedge mclk_i);
    #1 ev[1].crc_error_pulse = 0;
    while (dn !== 1'b1 && i < 4)
    begin
      @(posedge mclk_i);
      #1 i++;
    end
    if (dn !== 1'b1)
    begin
      error_cnt++;
      conclude();
    end
    else
    begin
      cmp("same", 8'h43, hd);
      cmp("hit", 8'h01, {7'h00, hm});
    end
    rd(8'h4D, 8'h63, "same2");
    $display("done same");
  endtask : t_same
  initial
  begin
    repeat (12) @(posedge mclk_i);
    #1 rst_n_i = 1;
    t_lock();
    t_crc();
    t_enh();
    t_par();
    t_same();
    conclude();
  end
endmodule : tb_top
bind rx_port_link_status rx_status_chk rx_status_chk_inst (.mclk_i, .rst_n_i, .rd_strobe_i,
  .rd_addr_i, .port_page_select_i, .port_events_i, .rd_data_o, .rd_valid_o, .rd_hit_o);
`default_nettype wire
